/* File: common/tat_pkg.sv */
// Package of constants, register map and types for the temperature alert block
package tat_pkg;

  // Register byte offsets on the Wishbone slave
  localparam logic [7:0] ADDR_CONFIG = 8'h00;
  localparam logic [7:0] ADDR_TEMP = 8'h04;
  localparam logic [7:0] ADDR_TLOW = 8'h08;
  localparam logic [7:0] ADDR_THIGH = 8'h0c;
  localparam logic [7:0] ADDR_STATUS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h14;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h18;

  // Config field positions
  localparam int CFG_SHUTDOWN = 0;
  localparam int CFG_POL_HIGH = 1;
  localparam int CFG_INT_MODE = 2;
  localparam int CFG_EXTENDED = 3;
  localparam int CFG_RATE_LSB = 4;
  localparam int CFG_FAULT_LSB = 6;

  // Status and interrupt bit positions
  localparam int ST_ALERT = 0;
  localparam int IRQ_CONV = 0;
  localparam int IRQ_ALERT = 1;

  // Reset values
  localparam logic [7:0] CONFIG_RESET = 8'h20;
  localparam logic [12:0] TLOW_RESET = 13'h04b0;
  localparam logic [12:0] THIGH_RESET = 13'h0500;
  localparam logic [1:0] IRQ_MASK_RESET = 2'h0;

  // Sample widths per resolution mode
  localparam int NORMAL_BITS = 12;
  localparam int EXTENDED_BITS = 13;

  // Conversion periods per rate setting, in microseconds
  localparam int CLK_MHZ = 100;
  localparam int RATE0_US = 4000;
  localparam int RATE1_US = 1000;
  localparam int RATE2_US = 250;
  localparam int RATE3_US = 125;
  localparam int RATE0_CYC = RATE0_US * CLK_MHZ;
  localparam int RATE1_CYC = RATE1_US * CLK_MHZ;
  localparam int RATE2_CYC = RATE2_US * CLK_MHZ;
  localparam int RATE3_CYC = RATE3_US * CLK_MHZ;

  // Decoded configuration
  typedef struct packed {
    logic [1:0] fault_sel;
    logic [1:0] rate;
    logic extended;
    logic int_mode;
    logic pol_high;
    logic shutdown;
  } tat_cfg_t;

  // One converted sample
  typedef struct packed {
    logic valid;
    logic [12:0] value;
  } tat_sample_t;

endpackage

/* File: hw/tat_conv_timer.sv */
// Conversion pacing timer: strobes a sample at the selected rate
module tat_conv_timer #(
  parameter int RATE0_CYCLES = tat_pkg::RATE0_CYC,
  parameter int RATE1_CYCLES = tat_pkg::RATE1_CYC,
  parameter int RATE2_CYCLES = tat_pkg::RATE2_CYC,
  parameter int RATE3_CYCLES = tat_pkg::RATE3_CYC
) (
  input wire logic clk_sys, // System clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic run, // Conversions enabled
  input wire logic [1:0] rate, // Rate selection
  output logic tick // One-cycle conversion done
);

  logic [31:0] count;
  logic [31:0] limit;

  // Period for the selected rate
  always_comb begin
    case (rate)
      2'h0: limit = 32'(RATE0_CYCLES);
      2'h1: limit = 32'(RATE1_CYCLES);
      2'h2: limit = 32'(RATE2_CYCLES);
      default: limit = 32'(RATE3_CYCLES);
    endcase
  end

  // Free counter cleared to zero while stopped
  always_ff @(posedge clk_sys) begin
    if (!reset_n || !run) begin
      count <= 32'h0;
      tick <= 1'b0;
    end else if (count + 32'h1 >= limit) begin
      count <= 32'h0;
      tick <= 1'b1;
    end else begin
      count <= count + 32'h1;
      tick <= 1'b0;
    end
  end

endmodule

/* File: hw/tat_top.sv */
// Temperature alert and thermostat logic with Wishbone register access
// How it works
// - With low polarity the alert pin is pulled to ground while alert holds and released otherwise.
// - With high polarity the alert pin is driven to the digital supply level while alert holds.
// - Shutdown stops all conversions until it is cleared.
// - In interrupt mode entering shutdown arms the release of a latched alert just like a register read.
// - Normal mode keeps temperature as a 12-bit value with 120 C full scale; the limits keep all 13 bits.
// - Extended mode keeps all three as 13-bit values with 150 C full scale.
// - In comparator mode alert rises after the set number of faults above the upper limit.
// - In comparator mode alert stays until the set number of conversions below the lower limit.
// - In interrupt mode alert does not drop just because the temperature falls below the lower limit.
// - In interrupt mode after a read or shutdown the alert clears once the temperature is below the lower limit.
// - A selectable rate sets the time per conversion, slower saving power.
// - A fault count setting decides how many faults are needed before alert activates.
// - Each conversion above the upper limit counts as one fault.
// - A readable status bit shows the alert state next to the limit registers.
// - Registers are reached by a two-wire serial host, bridged here onto a Wishbone slave.
//
// Added by the designer: the placing of the registers and the Wishbone slave port.
module tat_top #(
  parameter int RATE0_CYCLES = tat_pkg::RATE0_CYC, // Slowest conversion period
  parameter int RATE1_CYCLES = tat_pkg::RATE1_CYC, // Second period
  parameter int RATE2_CYCLES = tat_pkg::RATE2_CYC, // Third period
  parameter int RATE3_CYCLES = tat_pkg::RATE3_CYC // Fastest conversion period
) (
  input wire logic clk_sys, // System clock 100 MHz
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write enable
  input wire logic [7:0] wb_adr_i, // Wishbone byte address
  input wire logic [3:0] wb_sel_i, // Wishbone byte selects
  input wire logic [31:0] wb_dat_i, // Wishbone write data
  output logic [31:0] wb_dat_o, // Wishbone read data
  output logic wb_ack_o, // Wishbone acknowledge
  input wire logic [12:0] adc_value, // Raw sample from converter, other domain
  output logic alert_o, // Alert pin output level
  output logic alert_oe, // Alert pin output enable
  output logic irq // Level interrupt
);

  tat_pkg::tat_cfg_t cfg;
  logic [12:0] temp;
  logic [12:0] tlow;
  logic [12:0] thigh;
  logic alert;
  logic clear_armed;
  logic [2:0] fault_cnt;
  logic [2:0] fault_need;
  logic [1:0] irq_stat;
  logic [1:0] irq_mask;
  logic tick;
  logic shutdown_q;
  logic [12:0] adc_s1;
  logic [12:0] adc_s2;
  logic [12:0] adc_s3;
  logic wb_req;
  logic wb_wr;
  logic wb_rd;
  logic [12:0] sample;
  logic [12:0] next_temp;
  logic above;
  logic below;
  logic pend;
  logic fault_done;
  logic armed_clear;
  logic [1:0] irq_set;
  logic [31:0] rd_data;

  // Bus decode, a request is taken while ack is low
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_req && wb_we_i && wb_sel_i[0];
  assign wb_rd = wb_req && !wb_we_i;

  // Three-stage capture of the converter word
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      adc_s1 <= 13'h0;
      adc_s2 <= 13'h0;
      adc_s3 <= 13'h0;
    end else begin
      adc_s1 <= adc_value;
      adc_s2 <= adc_s1;
      adc_s3 <= adc_s2;
    end
  end

  // Take the word only when the last two stages agree
  assign sample = (adc_s2 == adc_s3) ? adc_s3 : temp;

  // Conversion pacing, halted in shutdown
  tat_conv_timer #(
    .RATE0_CYCLES(RATE0_CYCLES),
    .RATE1_CYCLES(RATE1_CYCLES),
    .RATE2_CYCLES(RATE2_CYCLES),
    .RATE3_CYCLES(RATE3_CYCLES)
  ) tat_conv_timer_i (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .run(!cfg.shutdown),
    .rate(cfg.rate),
    .tick(tick)
  );

  // Resolution: normal drops the lowest bit
  always_comb begin
    if (cfg.extended) begin
      next_temp = sample;
    end else begin
      next_temp = {sample[12:1], 1'b0};
    end
  end

  // Limit comparisons on the new sample, before it is stored
  assign above = $signed(next_temp) > $signed(thigh);
  assign below = $signed(next_temp) < $signed(tlow);
  assign pend = alert ? below : above;

  // Filter completion and armed release of a latched alert
  assign fault_done = tick && pend && (fault_cnt + 3'h1 >= fault_need);
  assign armed_clear = tick && alert && cfg.int_mode && clear_armed && below;

  // Fault count needed: 1, 2, 4 or 6
  always_comb begin
    case (cfg.fault_sel)
      2'h0: fault_need = 3'h1;
      2'h1: fault_need = 3'h2;
      2'h2: fault_need = 3'h4;
      default: fault_need = 3'h6;
    endcase
  end

  // Configuration register
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      cfg <= tat_pkg::tat_cfg_t'(tat_pkg::CONFIG_RESET);
    end else if (wb_wr && wb_adr_i == tat_pkg::ADDR_CONFIG) begin
      cfg <= tat_pkg::tat_cfg_t'(wb_dat_i[7:0]);
    end
  end

  // Lower limit, rewritten by the host after a mode switch
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      tlow <= tat_pkg::TLOW_RESET;
    end else if (wb_req && wb_we_i && wb_adr_i == tat_pkg::ADDR_TLOW) begin
      if (wb_sel_i[0]) tlow[7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1]) tlow[12:8] <= wb_dat_i[12:8];
    end
  end

  // Upper limit, same byte lanes
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      thigh <= tat_pkg::THIGH_RESET;
    end else if (wb_req && wb_we_i && wb_adr_i == tat_pkg::ADDR_THIGH) begin
      if (wb_sel_i[0]) thigh[7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1]) thigh[12:8] <= wb_dat_i[12:8];
    end
  end

  // Temperature register, once per conversion
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      temp <= 13'h0;
    end else if (tick) begin
      temp <= next_temp;
    end
  end

  // Fault counter, restarts on a miss, a full filter or a released alert
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      fault_cnt <= 3'h0;
    end else if (tick) begin
      if (!pend || armed_clear) begin
        fault_cnt <= 3'h0;
      end else if (fault_done) begin
        fault_cnt <= 3'h0;
      end else begin
        fault_cnt <= fault_cnt + 3'h1;
      end
    end
  end

  // Shutdown edge detector
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      shutdown_q <= 1'b0;
    end else begin
      shutdown_q <= cfg.shutdown;
    end
  end

  // Interrupt-mode clear arming by read or shutdown entry
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      clear_armed <= 1'b0;
    end else if (!cfg.int_mode || !alert) begin
      clear_armed <= 1'b0;
    end else if (wb_rd || (cfg.shutdown && !shutdown_q)) begin
      clear_armed <= 1'b1;
    end
  end

  // Alert state per thermostat mode
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      alert <= 1'b0;
    end else if (armed_clear) begin
      alert <= 1'b0;
    end else if (fault_done) begin
      if (!alert) begin
        alert <= 1'b1;
      end else if (!cfg.int_mode) begin
        alert <= 1'b0;
      end else begin
        alert <= 1'b1;
      end
    end
  end

  // Alert pin drive by polarity
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      alert_o <= 1'b0;
      alert_oe <= 1'b0;
    end else if (cfg.pol_high) begin
      alert_o <= alert;
      alert_oe <= 1'b1;
    end else begin
      alert_o <= 1'b0;
      alert_oe <= alert;
    end
  end

  // Events that set the sticky bits
  assign irq_set[tat_pkg::IRQ_CONV] = tick;
  assign irq_set[tat_pkg::IRQ_ALERT] = fault_done && !alert;

  // Sticky interrupt status, set wins over write-one clear
  for (genvar i = 0; i < 2; i++) begin : g_irq_stat
    always_ff @(posedge clk_sys) begin
      if (!reset_n) begin
        irq_stat[i] <= 1'b0;
      end else if (irq_set[i]) begin
        irq_stat[i] <= 1'b1;
      end else if (wb_wr && wb_adr_i == tat_pkg::ADDR_IRQ_STAT && wb_dat_i[i]) begin
        irq_stat[i] <= 1'b0;
      end
    end
  end

  // Interrupt mask
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      irq_mask <= tat_pkg::IRQ_MASK_RESET;
    end else if (wb_wr && wb_adr_i == tat_pkg::ADDR_IRQ_MASK) begin
      irq_mask <= wb_dat_i[1:0];
    end
  end

  // Level interrupt while an unmasked bit is set
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat & irq_mask);
    end
  end

  // Read mux, unmapped addresses read zero
  always_comb begin
    case (wb_adr_i)
      tat_pkg::ADDR_CONFIG: rd_data = {24'h0, 8'(cfg)};
      tat_pkg::ADDR_TEMP: rd_data = {{19{temp[12]}}, temp};
      tat_pkg::ADDR_TLOW: rd_data = {{19{tlow[12]}}, tlow};
      tat_pkg::ADDR_THIGH: rd_data = {{19{thigh[12]}}, thigh};
      tat_pkg::ADDR_STATUS: rd_data = {31'h0, alert};
      tat_pkg::ADDR_IRQ_STAT: rd_data = {30'h0, irq_stat};
      tat_pkg::ADDR_IRQ_MASK: rd_data = {30'h0, irq_mask};
      default: rd_data = 32'h0;
    endcase
  end

  // Wishbone acknowledge, one cycle after request
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_req;
    end
  end

  // Read data, valid with ack only
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      wb_dat_o <= 32'h0;
    end else begin
      wb_dat_o <= wb_rd ? rd_data : 32'h0;
    end
  end

endmodule

/* File: verif/tat_top_asserts.sv */
// Checker of bus and alert pin relations at the top ports
module tat_top_asserts (
  input wire logic clk_sys, // Clock
  input wire logic reset_n, // Reset, active low
  input wire logic wb_cyc_i, // Cycle
  input wire logic wb_stb_i, // Strobe
  input wire logic wb_we_i, // Write enable
  input wire logic [7:0] wb_adr_i, // Address
  input wire logic [31:0] wb_dat_o, // Read data
  input wire logic wb_ack_o, // Acknowledge
  input wire logic alert_o, // Pin level
  input wire logic alert_oe, // Pin enable
  input wire logic irq // Interrupt
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // Request not yet answered
  wire logic req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  property p_ack_next; req |=> wb_ack_o; endproperty
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  property p_no_stray; !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o; endproperty
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  property p_unmapped; req && !wb_we_i && wb_adr_i > 8'h18 |=> wb_dat_o == 32'h0; endproperty
  property p_od_low; !alert_oe |-> !alert_o; endproperty
  property p_high_drive; $rose(alert_o) |-> alert_oe; endproperty
  property p_reset_out; $rose(reset_n) |-> !wb_ack_o && !irq && !alert_oe && !alert_o; endproperty
  a_ack_next: assert property (p_ack_next) else $error("ack missing after request");
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  a_no_stray: assert property (p_no_stray) else $error("ack without request");
  a_dat_idle: assert property (p_dat_idle) else $error("read data outside ack");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_od_low: assert property (p_od_low) else $error("pin driven high while released");
  a_high_drive: assert property (p_high_drive) else $error("pin high without enable");
  a_reset_out: assert property (p_reset_out) else $error("outputs active after reset");
  // Main scenarios
  c_read: cover property (req && !wb_we_i);
  c_alert_hi: cover property ($rose(alert_o));
  c_alert_rel: cover property ($fell(alert_oe));
endmodule

/* File: verif/tat_adc_model.sv */
// Converter model standing in for the sensing element
module tat_adc_model (
  input wire logic clk_sys, // System clock
  input wire logic [12:0] temp_set, // Temperature to present
  output logic [12:0] adc_value // Raw sample to the block
);
  timeunit 1ns;
  timeprecision 1ps;
  // Present the set temperature one cycle later
  always_ff @(posedge clk_sys) begin
    adc_value <= temp_set;
  end
endmodule

/* File: verif/tat_top_tb.sv */
// Self-checking testbench of the temperature alert block
module tat_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, alert_o, alert_oe, irq;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [12:0] adc_value, temp_set, hi, lo;
  int errors, tests_run;
  logic [31:0] q[$];
  tat_top #(.RATE0_CYCLES(20), .RATE1_CYCLES(15), .RATE2_CYCLES(10), .RATE3_CYCLES(5)) tat_top_i (
    .clk_sys(clk_sys), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .adc_value(adc_value), .alert_o(alert_o), .alert_oe(alert_oe), .irq(irq));
  tat_adc_model tat_adc_model_i (.clk_sys(clk_sys), .temp_set(temp_set), .adc_value(adc_value));
  // Clock
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  task automatic chkd(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chkp(input string n, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("ERROR %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge clk_sys);
  endtask
  // Classic single cycle, held until ack is sampled
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do @(posedge clk_sys); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    q.push_back(e);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic end_of_test;
    if (errors == 0 && tests_run > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Read data checked against the oldest note
  always @(posedge clk_sys) begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) chkd("wb_dat_o", q.pop_front(), wb_dat_o);
  end
  // Watchdog
  initial begin
    #50us;
    errors++;
    end_of_test();
  end
  initial begin
    reset_n = 1'b0;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    temp_set = 13'h0100;
    errors = 0;
    tests_run = 0;
    void'($urandom(29771));
    hi = 13'h0600 + 13'($urandom % 256);
    lo = 13'($urandom % 1024);
    w(3);
    reset_n <= 1'b1;
    w(1);
    rd(tat_pkg::ADDR_CONFIG, 32'h20);
    rd(tat_pkg::ADDR_TLOW, 32'h4b0);
    rd(tat_pkg::ADDR_THIGH, 32'h500);
    rd(tat_pkg::ADDR_IRQ_MASK, 32'h0);
    rd(8'h1c, 32'h0);
    // Comparator, low polarity, six faults, fastest rate
    bus(1'b1, tat_pkg::ADDR_CONFIG, 32'hf0);
    temp_set <= hi;
    w(25);
    chkp("alert_oe", 1'b0, alert_oe);
    w(35);
    chkp("alert_oe", 1'b1, alert_oe);
    chkp("alert_o", 1'b0, alert_o);
    chkp("irq", 1'b0, irq);
    rd(tat_pkg::ADDR_STATUS, 32'h1);
    rd(tat_pkg::ADDR_TEMP, {19'h0, hi[12:1], 1'b0});
    temp_set <= lo;
    w(60);
    chkp("alert_oe", 1'b0, alert_oe);
    // Extended mode, limits written again
    bus(1'b1, tat_pkg::ADDR_CONFIG, 32'h38);
    bus(1'b1, tat_pkg::ADDR_TLOW, 32'h4b0);
    bus(1'b1, tat_pkg::ADDR_THIGH, 32'h500);
    w(30);
    rd(tat_pkg::ADDR_TEMP, {19'h0, lo});
    // Interrupt mode, high polarity, one fault
    bus(1'b1, tat_pkg::ADDR_IRQ_STAT, 32'h3);
    bus(1'b1, tat_pkg::ADDR_IRQ_MASK, 32'h2);
    chkp("irq", 1'b0, irq);
    bus(1'b1, tat_pkg::ADDR_CONFIG, 32'h3e);
    temp_set <= hi;
    w(30);
    chkp("alert_o", 1'b1, alert_o);
    chkp("irq", 1'b1, irq);
    bus(1'b1, tat_pkg::ADDR_IRQ_STAT, 32'h2);
    w(2);
    chkp("irq", 1'b0, irq);
    temp_set <= lo;
    w(30);
    chkp("alert_o", 1'b1, alert_o);
    rd(tat_pkg::ADDR_TEMP, {19'h0, lo});
    w(20);
    chkp("alert_o", 1'b0, alert_o);
    temp_set <= hi;
    w(30);
    chkp("alert_o", 1'b1, alert_o);
    temp_set <= lo;
    w(30);
    bus(1'b1, tat_pkg::ADDR_CONFIG, 32'h3f);
    temp_set <= hi;
    w(30);
    rd(tat_pkg::ADDR_TEMP, {19'h0, lo});
    temp_set <= lo;
    w(10);
    bus(1'b1, tat_pkg::ADDR_CONFIG, 32'h3e);
    w(30);
    chkp("alert_o", 1'b0, alert_o);
    // Reset in mid-run, then slower rates with longer filters
    reset_n <= 1'b0;
    w(3);
    reset_n <= 1'b1;
    w(1);
    chkp("alert_oe", 1'b0, alert_oe);
    chkp("irq", 1'b0, irq);
    rd(tat_pkg::ADDR_CONFIG, 32'h20);
    bus(1'b1, tat_pkg::ADDR_CONFIG, 32'h80);
    temp_set <= hi;
    w(60);
    chkp("alert_oe", 1'b0, alert_oe);
    w(30);
    chkp("alert_oe", 1'b1, alert_oe);
    bus(1'b1, tat_pkg::ADDR_CONFIG, 32'h50);
    temp_set <= lo;
    w(18);
    chkp("alert_oe", 1'b1, alert_oe);
    w(32);
    chkp("alert_oe", 1'b0, alert_oe);
    end_of_test();
  end
endmodule
bind tat_top tat_top_asserts tat_top_asserts_i (.clk_sys(clk_sys), .reset_n(reset_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .alert_o(alert_o), .alert_oe(alert_oe), .irq(irq));
